// ---- rtl/gpio_ports_defs.vh ----
`ifndef GPIO_PORTS_DEFS_VH
`define GPIO_PORTS_DEFS_VH

// Register addresses on the special-function register bus.
`define ADDR_PORT2_DATA 16'hff02
`define ADDR_PORT3_DATA 16'hff03
`define ADDR_PORT4_DATA 16'hff04
`define ADDR_PORT2_DIRECTION 16'hff22
`define ADDR_PORT3_DIRECTION 16'hff23
`define ADDR_PORT4_DIRECTION 16'hff24
`define ADDR_PORT2_PULLUP 16'hff32
`define ADDR_PORT3_PULLUP 16'hff33
`define ADDR_PORT4_PULLUP 16'hff34

// Implemented bit masks per port.
`define PORT2_IO_MASK 8'h0f
`define PORT3_IO_MASK 8'h04
`define PORT3_PULLUP_MASK 8'h14
`define PORT3_INPUT_ONLY_BIT 4
`define PORT3_IO_BIT 2
`define PORT2_CLOCK_PIN_BIT 3
`define PORT4_IO_MASK 8'h09

// Reset values.
`define DIRECTION_RESET 8'hff
`define DATA_RESET 8'h00
`define PULLUP_RESET 8'h00

`endif

// ---- rtl/gpio_pin_bit.v ----
`timescale 1ns/1ps
`default_nettype none

// One bidirectional port bit: direction, output latch, pull-up and read mux.
module gpio_pin_bit (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire usable_in,
  input wire dir_we_in,
  input wire dir_wd_in,
  input wire data_we_in,
  input wire data_wd_in,
  input wire pull_we_in,
  input wire pull_wd_in,
  input wire pin_level_in,
  output reg dir_out,
  output reg latch_out,
  output reg pull_out,
  output reg read_out,
  output reg pin_o_out,
  output reg pin_oe_out,
  output reg pull_en_out
);

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      dir_out <= 1'b1;
      latch_out <= 1'b0;
      pull_out <= 1'b0;
      read_out <= 1'b0;
      pin_o_out <= 1'b0;
      pin_oe_out <= 1'b0;
      pull_en_out <= 1'b0;
    end else begin
      if (dir_we_in) begin
        dir_out <= dir_wd_in;
      end
      if (data_we_in) begin
        latch_out <= data_wd_in;
      end
      if (pull_we_in) begin
        pull_out <= pull_wd_in;
      end
      read_out <= dir_out ? pin_level_in : latch_out;
      pin_o_out <= latch_out;
      pin_oe_out <= usable_in & ~dir_out;
      pull_en_out <= usable_in & dir_out & pull_out;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/gpio_ports_two_to_four.v ----
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ports_defs.vh"

module gpio_ports_two_to_four (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire [15:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_wdata_in,
  output reg [7:0] sfr_rdata_out,
  output reg sfr_hit_out,
  input wire clock_is_internal_in,
  input wire option_valid_in,
  input wire bit4_is_input_in,
  input wire [3:0] port2_pin_in,
  output wire [3:0] port2_pin_o_out,
  output wire [3:0] port2_pin_oe_out,
  output wire [3:0] port2_pullup_out,
  input wire port3_bit2_pin_in,
  output wire port3_bit2_pin_o_out,
  output wire port3_bit2_pin_oe_out,
  output wire port3_bit2_pullup_out,
  input wire port3_bit4_pin_in,
  output reg port3_bit4_pullup_out,
  output reg chip_reset_hold_out,
  input wire [1:0] port4_pin_in,
  output wire [1:0] port4_pin_o_out,
  output wire [1:0] port4_pin_oe_out,
  output wire [1:0] port4_pullup_out,
  output reg [1:0] ext_int_pin_out
);

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  wire wr_p2d = sfr_wr_in && (sfr_addr_in == `ADDR_PORT2_DATA);
  wire wr_p3d = sfr_wr_in && (sfr_addr_in == `ADDR_PORT3_DATA);
  wire wr_p4d = sfr_wr_in && (sfr_addr_in == `ADDR_PORT4_DATA);
  wire wr_p2m = sfr_wr_in && (sfr_addr_in == `ADDR_PORT2_DIRECTION);
  wire wr_p3m = sfr_wr_in && (sfr_addr_in == `ADDR_PORT3_DIRECTION);
  wire wr_p4m = sfr_wr_in && (sfr_addr_in == `ADDR_PORT4_DIRECTION);
  wire wr_p2u = sfr_wr_in && (sfr_addr_in == `ADDR_PORT2_PULLUP);
  wire wr_p3u = sfr_wr_in && (sfr_addr_in == `ADDR_PORT3_PULLUP);
  wire wr_p4u = sfr_wr_in && (sfr_addr_in == `ADDR_PORT4_PULLUP);

  // ****************************************************************
  // Seven bidirectional bits: port 2 bits 0-3, port 3 bit 2, port 4 bits 0 and 3.
  // ****************************************************************
  wire [6:0] usable;
  wire [6:0] dir_we;
  wire [6:0] data_we;
  wire [6:0] pull_we;
  wire [6:0] wd_bit;
  wire [6:0] pin_lvl;
  wire [6:0] dir_bit;
  wire [6:0] latch_bit;
  wire [6:0] pull_bit;
  wire [6:0] read_bit;
  wire [6:0] pin_o;
  wire [6:0] pin_oe;
  wire [6:0] pull_en;

  // Port 2 bit 3 is the clock input whenever the external clock is selected.
  assign usable = {3'b111, clock_is_internal_in, 3'b111};
  // Every register write is a whole byte; bit operations come in as merged bytes.
  assign dir_we = {{2{wr_p4m}}, wr_p3m, {4{wr_p2m}}};
  assign data_we = {{2{wr_p4d}}, wr_p3d, {4{wr_p2d}}};
  assign pull_we = {{2{wr_p4u}}, wr_p3u, {4{wr_p2u}}};
  assign wd_bit = {sfr_wdata_in[3], sfr_wdata_in[0], sfr_wdata_in[2], sfr_wdata_in[3:0]};
  assign pin_lvl = {port4_pin_in[1], port4_pin_in[0], port3_bit2_pin_in, port2_pin_in};

  // ****************************************************************
  // Port 2 bits 0 to 3.
  // ****************************************************************
  gpio_pin_bit u_port2_bit0 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .usable_in(usable[0]),
    .dir_we_in(dir_we[0]),
    .dir_wd_in(wd_bit[0]),
    .data_we_in(data_we[0]),
    .data_wd_in(wd_bit[0]),
    .pull_we_in(pull_we[0]),
    .pull_wd_in(wd_bit[0]),
    .pin_level_in(pin_lvl[0]),
    .dir_out(dir_bit[0]),
    .latch_out(latch_bit[0]),
    .pull_out(pull_bit[0]),
    .read_out(read_bit[0]),
    .pin_o_out(pin_o[0]),
    .pin_oe_out(pin_oe[0]),
    .pull_en_out(pull_en[0])
  );

  gpio_pin_bit u_port2_bit1 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .usable_in(usable[1]),
    .dir_we_in(dir_we[1]),
    .dir_wd_in(wd_bit[1]),
    .data_we_in(data_we[1]),
    .data_wd_in(wd_bit[1]),
    .pull_we_in(pull_we[1]),
    .pull_wd_in(wd_bit[1]),
    .pin_level_in(pin_lvl[1]),
    .dir_out(dir_bit[1]),
    .latch_out(latch_bit[1]),
    .pull_out(pull_bit[1]),
    .read_out(read_bit[1]),
    .pin_o_out(pin_o[1]),
    .pin_oe_out(pin_oe[1]),
    .pull_en_out(pull_en[1])
  );

  gpio_pin_bit u_port2_bit2 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .usable_in(usable[2]),
    .dir_we_in(dir_we[2]),
    .dir_wd_in(wd_bit[2]),
    .data_we_in(data_we[2]),
    .data_wd_in(wd_bit[2]),
    .pull_we_in(pull_we[2]),
    .pull_wd_in(wd_bit[2]),
    .pin_level_in(pin_lvl[2]),
    .dir_out(dir_bit[2]),
    .latch_out(latch_bit[2]),
    .pull_out(pull_bit[2]),
    .read_out(read_bit[2]),
    .pin_o_out(pin_o[2]),
    .pin_oe_out(pin_oe[2]),
    .pull_en_out(pull_en[2])
  );

  gpio_pin_bit u_port2_bit3 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .usable_in(usable[3]),
    .dir_we_in(dir_we[3]),
    .dir_wd_in(wd_bit[3]),
    .data_we_in(data_we[3]),
    .data_wd_in(wd_bit[3]),
    .pull_we_in(pull_we[3]),
    .pull_wd_in(wd_bit[3]),
    .pin_level_in(pin_lvl[3]),
    .dir_out(dir_bit[3]),
    .latch_out(latch_bit[3]),
    .pull_out(pull_bit[3]),
    .read_out(read_bit[3]),
    .pin_o_out(pin_o[3]),
    .pin_oe_out(pin_oe[3]),
    .pull_en_out(pull_en[3])
  );

  // ****************************************************************
  // Port 3 bit 2.
  // ****************************************************************
  gpio_pin_bit u_port3_bit2 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .usable_in(usable[4]),
    .dir_we_in(dir_we[4]),
    .dir_wd_in(wd_bit[4]),
    .data_we_in(data_we[4]),
    .data_wd_in(wd_bit[4]),
    .pull_we_in(pull_we[4]),
    .pull_wd_in(wd_bit[4]),
    .pin_level_in(pin_lvl[4]),
    .dir_out(dir_bit[4]),
    .latch_out(latch_bit[4]),
    .pull_out(pull_bit[4]),
    .read_out(read_bit[4]),
    .pin_o_out(pin_o[4]),
    .pin_oe_out(pin_oe[4]),
    .pull_en_out(pull_en[4])
  );

  // ****************************************************************
  // Port 4 bits 0 and 3.
  // ****************************************************************
  gpio_pin_bit u_port4_bit0 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .usable_in(usable[5]),
    .dir_we_in(dir_we[5]),
    .dir_wd_in(wd_bit[5]),
    .data_we_in(data_we[5]),
    .data_wd_in(wd_bit[5]),
    .pull_we_in(pull_we[5]),
    .pull_wd_in(wd_bit[5]),
    .pin_level_in(pin_lvl[5]),
    .dir_out(dir_bit[5]),
    .latch_out(latch_bit[5]),
    .pull_out(pull_bit[5]),
    .read_out(read_bit[5]),
    .pin_o_out(pin_o[5]),
    .pin_oe_out(pin_oe[5]),
    .pull_en_out(pull_en[5])
  );

  gpio_pin_bit u_port4_bit3 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .usable_in(usable[6]),
    .dir_we_in(dir_we[6]),
    .dir_wd_in(wd_bit[6]),
    .data_we_in(data_we[6]),
    .data_wd_in(wd_bit[6]),
    .pull_we_in(pull_we[6]),
    .pull_wd_in(wd_bit[6]),
    .pin_level_in(pin_lvl[6]),
    .dir_out(dir_bit[6]),
    .latch_out(latch_bit[6]),
    .pull_out(pull_bit[6]),
    .read_out(read_bit[6]),
    .pin_o_out(pin_o[6]),
    .pin_oe_out(pin_oe[6]),
    .pull_en_out(pull_en[6])
  );

  assign port2_pin_o_out = pin_o[3:0];
  assign port2_pin_oe_out = pin_oe[3:0];
  assign port2_pullup_out = pull_en[3:0];
  assign port3_bit2_pin_o_out = pin_o[4];
  assign port3_bit2_pin_oe_out = pin_oe[4];
  assign port3_bit2_pullup_out = pull_en[4];
  assign port4_pin_o_out = pin_o[6:5];
  assign port4_pin_oe_out = pin_oe[6:5];
  assign port4_pullup_out = pull_en[6:5];

  // ****************************************************************
  // Input-only bit, its pull-up and the shared reset role.
  // ****************************************************************
  reg pull34_q;
  reg in34_q;

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pull34_q <= 1'b0;
      port3_bit4_pullup_out <= 1'b0;
    end else begin
      if (wr_p3u) begin
        pull34_q <= sfr_wdata_in[`PORT3_INPUT_ONLY_BIT];
      end
      // The reset pull-up stays on until the option says the pin is a plain input.
      port3_bit4_pullup_out <= (option_valid_in && bit4_is_input_in) ? pull34_q : 1'b1;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      in34_q <= 1'b0;
      chip_reset_hold_out <= 1'b1;
    end else begin
      in34_q <= port3_bit4_pin_in;
      // Until the option is read, or when the pin stays a reset pin, low holds reset.
      chip_reset_hold_out <= (!option_valid_in || !bit4_is_input_in) && !port3_bit4_pin_in;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ext_int_pin_out <= 2'b00;
    end else begin
      // Interrupt sense sees the pad level, also the one this port drives.
      ext_int_pin_out[0] <= pin_oe[1] ? pin_o[1] : port2_pin_in[1];
      ext_int_pin_out[1] <= pin_oe[4] ? pin_o[4] : port3_bit2_pin_in;
    end
  end

  // ****************************************************************
  // Read words with the fixed bits of each register filled in.
  // ****************************************************************
  wire [7:0] port2_data_word;
  wire [7:0] port3_data_word;
  wire [7:0] port4_data_word;
  wire [7:0] port2_dir_word;
  wire [7:0] port3_dir_word;
  wire [7:0] port4_dir_word;
  wire [7:0] port2_pull_word;
  wire [7:0] port3_pull_word;
  wire [7:0] port4_pull_word;

  assign port2_data_word = {4'h0, read_bit[3:0]};
  assign port3_data_word = {3'b000, in34_q, 1'b0, read_bit[4], 2'b00};
  assign port4_data_word = {4'h0, read_bit[6], 2'b00, read_bit[5]};
  assign port2_dir_word = {4'hf, dir_bit[3:0]};
  assign port3_dir_word = {5'h1f, dir_bit[4], 2'b11};
  assign port4_dir_word = {4'hf, dir_bit[6], 2'b11, dir_bit[5]};
  assign port2_pull_word = {4'h0, pull_bit[3:0]};
  assign port3_pull_word = {3'b000, pull34_q, 1'b0, pull_bit[4], 2'b00};
  assign port4_pull_word = {4'h0, pull_bit[6], 2'b00, pull_bit[5]};

  // ****************************************************************
  // Read data, one cycle after the read strobe.
  // ****************************************************************
  reg [7:0] rdata_d;
  reg hit_d;

  always @* begin
    rdata_d = 8'h00;
    hit_d = 1'b1;
    case (sfr_addr_in)
      `ADDR_PORT2_DATA: rdata_d = port2_data_word;
      `ADDR_PORT3_DATA: rdata_d = port3_data_word;
      `ADDR_PORT4_DATA: rdata_d = port4_data_word;
      `ADDR_PORT2_DIRECTION: rdata_d = port2_dir_word;
      `ADDR_PORT3_DIRECTION: rdata_d = port3_dir_word;
      `ADDR_PORT4_DIRECTION: rdata_d = port4_dir_word;
      `ADDR_PORT2_PULLUP: rdata_d = port2_pull_word;
      `ADDR_PORT3_PULLUP: rdata_d = port3_pull_word;
      `ADDR_PORT4_PULLUP: rdata_d = port4_pull_word;
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sfr_rdata_out <= 8'h00;
      sfr_hit_out <= 1'b0;
    end else begin
      sfr_rdata_out <= sfr_rd_in ? rdata_d : 8'h00;
      sfr_hit_out <= (sfr_rd_in || sfr_wr_in) && hit_d;
    end
  end

endmodule

`default_nettype wire

// ---- test/gpio_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_asserts (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_hit_out,
  input wire logic clock_is_internal_in,
  input wire logic option_valid_in,
  input wire logic port3_bit4_pin_in,
  input wire logic [3:0] port2_pin_oe_out,
  input wire logic chip_reset_hold_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_no_drive: assert property ($past(!rst_n_in) |-> port2_pin_oe_out == 4'h0)
    else $error("driver on after reset");
  a_clock_pin_off: assert property (!clock_is_internal_in [*3] |-> !port2_pin_oe_out[3])
    else $error("clock pin driven");
  a_dir_fixed_ones: assert property (sfr_rd_in && sfr_addr_in == 16'hff22 |=>
    sfr_hit_out && sfr_rdata_out[7:4] == 4'hf) else $error("direction fixed bits");
  a_data_fixed_zeros: assert property (sfr_rd_in && sfr_addr_in == 16'hff03 |=>
    (sfr_rdata_out & 8'heb) == 8'h00) else $error("data fixed bits");
  a_unmapped_quiet: assert property (sfr_rd_in && sfr_addr_in == 16'hff10 |=>
    !sfr_hit_out && sfr_rdata_out == 8'h00) else $error("unmapped read");
  a_dir_drives_pin: assert property (sfr_wr_in && sfr_addr_in == 16'hff22 ##1 !sfr_wr_in [*2]
    |=> port2_pin_oe_out[0] == !$past(sfr_wdata_in[0], 3)) else $error("direction to driver");
  a_pin_holds_reset: assert property ((!option_valid_in && !port3_bit4_pin_in) [*3]
    |-> chip_reset_hold_out) else $error("reset not held");
  a_pin_high_frees: assert property (port3_bit4_pin_in [*3] |-> !chip_reset_hold_out)
    else $error("reset held with pin high");
  cover property (sfr_rd_in && sfr_addr_in == 16'hff03);
  cover property (chip_reset_hold_out ##1 !chip_reset_hold_out);
  cover property (port2_pin_oe_out == 4'hf);
endmodule
`default_nettype wire

// ---- test/gpio_pads.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_pads (
  input wire logic sys_clk_in,
  input wire logic [6:0] pin_o_in,
  input wire logic [6:0] pin_oe_in,
  input wire logic [6:0] pullup_in,
  input wire logic [6:0] ext_en_in,
  input wire logic [6:0] ext_val_in,
  output logic [6:0] level_out
);
  // An undriven pin without pull-up toggles so that a stale level is never read as valid.
  logic [6:0] float_q = 7'h2a;
  always @(posedge sys_clk_in) begin
    float_q <= ~float_q;
  end
  assign level_out = (pin_oe_in & pin_o_in) | (~pin_oe_in & ext_en_in & ext_val_in)
    | (~pin_oe_in & ~ext_en_in & (pullup_in | float_q));
endmodule
`default_nettype wire

// ---- test/gpio_ports_two_to_four_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_two_to_four_tb_top;
  logic sys_clk_in = 0, rst_n_in = 0, sfr_wr_in = 0, sfr_rd_in = 0, rst_hold;
  logic clock_is_internal_in = 1, option_valid_in = 0, bit4_is_input_in = 0, bit4_pin = 1;
  logic [15:0] sfr_addr_in = 16'h0000;
  logic [7:0] sfr_wdata_in = 8'h00, sfr_rdata_out;
  wire [6:0] o, oe, pu, lvl;
  wire hit, pu34;
  wire [1:0] ext_int;
  logic [6:0] ext_en = 7'h7f, ext_val = 7'h00;
  int mismatches = 0, check_count = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  gpio_ports_two_to_four uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(hit),
    .clock_is_internal_in(clock_is_internal_in), .option_valid_in(option_valid_in),
    .bit4_is_input_in(bit4_is_input_in), .port2_pin_in(lvl[3:0]), .port2_pin_o_out(o[3:0]),
    .port2_pin_oe_out(oe[3:0]), .port2_pullup_out(pu[3:0]), .port3_bit2_pin_in(lvl[4]),
    .port3_bit2_pin_o_out(o[4]), .port3_bit2_pin_oe_out(oe[4]), .port3_bit2_pullup_out(pu[4]),
    .port3_bit4_pin_in(bit4_pin), .port3_bit4_pullup_out(pu34), .chip_reset_hold_out(rst_hold),
    .port4_pin_in(lvl[6:5]), .port4_pin_o_out(o[6:5]), .port4_pin_oe_out(oe[6:5]),
    .port4_pullup_out(pu[6:5]), .ext_int_pin_out(ext_int));
  gpio_pads pads (.sys_clk_in(sys_clk_in), .pin_o_in(o), .pin_oe_in(oe), .pullup_in(pu),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1;
    @(posedge sys_clk_in) #1;
    sfr_wr_in = 0;
    @(posedge sys_clk_in) #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    sfr_addr_in = a;
    sfr_rd_in = 1;
    @(posedge sys_clk_in) #1;
    sfr_rd_in = 0;
    chk(sfr_rdata_out, exp);
    chk({7'h00, hit}, {7'h00, a != 16'hff10});
    @(posedge sys_clk_in) #1;
  endtask
  task automatic t_reset_state;
    chk({1'b0, oe}, 8'h00);
    rd(16'hff22, 8'hff);
    chk({7'h00, pu34}, 8'h01);
    rd(16'hff24, 8'hff);
    rd(16'hff02, 8'h00);
    rd(16'hff33, 8'h00);
    rd(16'hff10, 8'h00);
  endtask
  task automatic t_port2_modes;
    ext_val = 7'h1f;
    wr(16'hff02, 8'hfa);
    chk({1'b0, oe}, 8'h00);
    rd(16'hff02, 8'h0f);
    wr(16'hff22, 8'h00);
    rd(16'hff22, 8'hf0);
    chk({4'h0, o[3:0] & oe[3:0]}, 8'h0a);
    rd(16'hff02, 8'h0a);
    clock_is_internal_in = 0;
    #24;
    chk({4'h0, oe[3:0]}, 8'h07);
    clock_is_internal_in = 1;
  endtask
  task automatic t_port3_port4;
    bit4_pin = 0;
    wr(16'hff23, 8'h00);
    rd(16'hff23, 8'hfb);
    wr(16'hff24, 8'h00);
    rd(16'hff24, 8'hf6);
    wr(16'hff03, 8'hff);
    wr(16'hff04, 8'hff);
    chk({1'b0, o & oe}, 8'h7a);
    rd(16'hff03, 8'h04);
    rd(16'hff04, 8'h09);
    chk({6'h00, ext_int}, 8'h03);
    wr(16'hff03, 8'h00);
    rd(16'hff03, 8'h00);
    chk({6'h00, ext_int}, 8'h01);
    chk({7'h00, rst_hold}, 8'h01);
    option_valid_in = 1;
    bit4_is_input_in = 1;
    #24;
    chk({7'h00, rst_hold}, 8'h00);
    chk({7'h00, pu34}, 8'h00);
    bit4_pin = 1;
  endtask
  task automatic t_pullups;
    wr(16'hff22, 8'hff);
    ext_en = 7'h00;
    wr(16'hff32, 8'hff);
    wr(16'hff33, 8'hff);
    rd(16'hff32, 8'h0f);
    rd(16'hff33, 8'h14);
    chk({7'h00, pu34}, 8'h01);
    chk({4'h0, pu[3:0]}, 8'h0f);
    rd(16'hff02, 8'h0f);
  endtask
  task automatic t_mid_reset;
    ext_en = 7'h7f;
    ext_val = 7'h7f;
    rst_n_in = 0;
    repeat (3) @(posedge sys_clk_in) #1;
    chk({1'b0, oe}, 8'h00);
    rst_n_in = 1;
    rd(16'hff24, 8'hff);
    rd(16'hff34, 8'h00);
    rd(16'hff02, 8'h0f);
    wr(16'hff22, 8'h00);
    rd(16'hff02, 8'h00);
  endtask
  task automatic test_done;
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    test_done;
  end
  initial begin
    #61;
    rst_n_in = 1;
    t_reset_state;
    t_port2_modes;
    t_port3_port4;
    t_pullups;
    t_mid_reset;
    test_done;
  end
endmodule
bind gpio_ports_two_to_four gpio_asserts chk_i (.sys_clk_in, .rst_n_in, .sfr_addr_in,
  .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .sfr_hit_out, .clock_is_internal_in,
  .option_valid_in, .port3_bit4_pin_in, .port2_pin_oe_out, .chip_reset_hold_out);
`default_nettype wire
